// [design/mem_pin_pkg.sv]
// constants, mode type and reset levels for the external memory port pin mux
package mem_pin_pkg;
  // ----------------------------------------------------------------
  // widths and bit positions
  // ----------------------------------------------------------------
  localparam int SHARED_W = 8;
  localparam int DYN_DATA_W = 4;
  localparam int DYN_LOW_ADDR_BASE = 4;
  localparam int STATIC_UPPER_LSB = 8;
  localparam int STATIC_UPPER_MSB = 12;
  localparam int STATIC_TOP_BIT = 13;
  localparam int DYN_UPPER_LSB = 4;
  localparam int DYN_UPPER_MSB = 8;
  localparam int DYN_ADDR_W = 9;
  localparam int SYNC_STAGES = 2;
  localparam int READ_LATENCY = 3;
  // ----------------------------------------------------------------
  // reset and idle levels
  // ----------------------------------------------------------------
  localparam logic [7:0] SHARED_OUT_IDLE = 8'hf0;
  localparam logic [7:0] SHARED_OE_IDLE = 8'hf0;
  localparam logic [4:0] UPPER_IDLE = 5'h1f;
  localparam logic STROBE_IDLE = 1'h1;
  // ----------------------------------------------------------------
  // pin function selection
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PIN_MODE_IDLE,
    PIN_MODE_STATIC,
    PIN_MODE_DYNAMIC
  } pin_mode_e;
endpackage : mem_pin_pkg

// [design/pin_sync.sv]
// two-stage synchroniser for pin inputs
`timescale 1ns/1ns
module pin_sync #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // raw and synchronised levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage_one;
  logic [WIDTH-1:0] stage_two;
  logic [WIDTH-1:0] next_stage_one;
  logic [WIDTH-1:0] next_stage_two;

  always_comb begin
    next_stage_one = async_in;
    next_stage_two = stage_one;
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stage_one <= '0;
      stage_two <= '0;
    end else begin
      stage_one <= next_stage_one;
      stage_two <= next_stage_two;
    end
  end

  assign sync_out = stage_two;
endmodule : pin_sync

// [design/memory_port_pin_mux.sv]
// pin function mux of the external memory port, static and dynamic memory modes
`timescale 1ns/1ns
// Notes on behaviour
// - static mode: shared line n carries multiplexed address/data bit n, both ways
// - dynamic mode: shared lines 4..7 output dynamic address bits 0..3
// - dynamic mode: shared lines 0..3 are the four bidirectional data bits
// - upper pins carry static address 8..12 or dynamic address 4..8 by mode
// - one pin is address latch enable in static, column strobe in dynamic
// - one pin is static address bit 13 or row address strobe in dynamic
// - one dedicated write enable pin serves both modes
// - one dedicated read enable pin serves both modes
module memory_port_pin_mux (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // mode setting
  input wire logic mode_configured_in,
  input wire logic mode_dynamic_in,
  // static memory controller side
  input wire logic [7:0] sram_ad_out_in,
  input wire logic sram_ad_oe_in,
  input wire logic [13:8] sram_addr_hi_in,
  input wire logic sram_ale_in,
  output logic [7:0] sram_ad_rd_out,
  // dynamic memory controller side
  input wire logic [8:0] dram_addr_in,
  input wire logic [3:0] dram_data_out_in,
  input wire logic dram_data_oe_in,
  input wire logic dram_ras_n_in,
  input wire logic dram_cas_n_in,
  output logic [3:0] dram_data_rd_out,
  // strobes common to both modes, active low
  input wire logic mem_write_enable_n_in,
  input wire logic mem_read_enable_n_in,
  // external memory port pins
  input wire logic [7:0] shared_line_in,
  output logic [7:0] shared_line_out,
  output logic [7:0] shared_line_oe_out,
  output logic [4:0] upper_addr_pin_out,
  output logic addr_latch_or_col_strobe_out,
  output logic top_addr_or_row_strobe_out,
  output logic mem_write_enable_n_out,
  output logic mem_read_enable_n_out,
  // current pin function
  output mem_pin_pkg::pin_mode_e mode_out
);
  // ----------------------------------------------------------------
  // mode selection
  // ----------------------------------------------------------------
  mem_pin_pkg::pin_mode_e next_mode;
  logic [7:0] next_line;
  logic [7:0] next_oe;
  logic [4:0] next_upper;
  logic next_ale_cas;
  logic next_top_ras;
  logic next_wr;
  logic next_rd;
  logic [7:0] line_sync;
  logic [7:0] next_sram_rd;
  logic [3:0] next_dram_rd;

  always_comb begin
    if (!mode_configured_in) begin
      next_mode = mem_pin_pkg::PIN_MODE_IDLE;
    end else if (mode_dynamic_in) begin
      next_mode = mem_pin_pkg::PIN_MODE_DYNAMIC;
    end else begin
      next_mode = mem_pin_pkg::PIN_MODE_STATIC;
    end
  end

  // ----------------------------------------------------------------
  // shared lines, one mux per line
  // ----------------------------------------------------------------
  // outputs are muxed from next_mode so pins and mode_out change on the same edge
  for (genvar i = 0; i < mem_pin_pkg::SHARED_W; i++) begin : g_line
    // the dynamic role of a line is fixed by its position; splitting at elaboration
    // keeps every select in range for every line
    logic dyn_bit;
    logic dyn_oe;
    if (i >= mem_pin_pkg::DYN_LOW_ADDR_BASE) begin : g_addr
      assign dyn_bit = dram_addr_in[i-mem_pin_pkg::DYN_LOW_ADDR_BASE];
      assign dyn_oe = 1'h1;
    end else begin : g_data
      assign dyn_bit = dram_data_out_in[i];
      assign dyn_oe = dram_data_oe_in;
    end
    always_comb begin
      next_line[i] = mem_pin_pkg::SHARED_OUT_IDLE[i];
      next_oe[i] = mem_pin_pkg::SHARED_OE_IDLE[i];
      case (next_mode)
        mem_pin_pkg::PIN_MODE_STATIC: begin
          next_line[i] = sram_ad_out_in[i];
          next_oe[i] = sram_ad_oe_in;
        end
        mem_pin_pkg::PIN_MODE_DYNAMIC: begin
          next_line[i] = dyn_bit;
          next_oe[i] = dyn_oe;
        end
        default: begin
          next_line[i] = mem_pin_pkg::SHARED_OUT_IDLE[i];
          next_oe[i] = mem_pin_pkg::SHARED_OE_IDLE[i];
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // dedicated pins
  // ----------------------------------------------------------------
  always_comb begin
    next_upper = mem_pin_pkg::UPPER_IDLE;
    next_ale_cas = mem_pin_pkg::STROBE_IDLE;
    next_top_ras = mem_pin_pkg::STROBE_IDLE;
    next_wr = mem_pin_pkg::STROBE_IDLE;
    next_rd = mem_pin_pkg::STROBE_IDLE;
    case (next_mode)
      mem_pin_pkg::PIN_MODE_STATIC: begin
        next_upper = sram_addr_hi_in[mem_pin_pkg::STATIC_UPPER_MSB:
                                     mem_pin_pkg::STATIC_UPPER_LSB];
        next_ale_cas = sram_ale_in;
        next_top_ras = sram_addr_hi_in[mem_pin_pkg::STATIC_TOP_BIT];
        next_wr = mem_write_enable_n_in;
        next_rd = mem_read_enable_n_in;
      end
      mem_pin_pkg::PIN_MODE_DYNAMIC: begin
        next_upper = dram_addr_in[mem_pin_pkg::DYN_UPPER_MSB:
                                  mem_pin_pkg::DYN_UPPER_LSB];
        next_ale_cas = dram_cas_n_in;
        next_top_ras = dram_ras_n_in;
        next_wr = mem_write_enable_n_in;
        next_rd = mem_read_enable_n_in;
      end
      default: begin
        next_upper = mem_pin_pkg::UPPER_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // read path from the pins
  // ----------------------------------------------------------------
  pin_sync #(
    .WIDTH(mem_pin_pkg::SHARED_W)
  ) u_line_sync (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .async_in(shared_line_in),
    .sync_out(line_sync)
  );

  // read data is passed in every mode; the controller knows when it samples
  always_comb begin
    next_sram_rd = line_sync;
    next_dram_rd = line_sync[mem_pin_pkg::DYN_DATA_W-1:0];
  end

  // ----------------------------------------------------------------
  // output registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mode_out <= mem_pin_pkg::PIN_MODE_IDLE;
      shared_line_out <= mem_pin_pkg::SHARED_OUT_IDLE;
      shared_line_oe_out <= mem_pin_pkg::SHARED_OE_IDLE;
      upper_addr_pin_out <= mem_pin_pkg::UPPER_IDLE;
      addr_latch_or_col_strobe_out <= mem_pin_pkg::STROBE_IDLE;
      top_addr_or_row_strobe_out <= mem_pin_pkg::STROBE_IDLE;
      mem_write_enable_n_out <= mem_pin_pkg::STROBE_IDLE;
      mem_read_enable_n_out <= mem_pin_pkg::STROBE_IDLE;
      sram_ad_rd_out <= 8'h00;
      dram_data_rd_out <= 4'h0;
    end else begin
      mode_out <= next_mode;
      shared_line_out <= next_line;
      shared_line_oe_out <= next_oe;
      upper_addr_pin_out <= next_upper;
      addr_latch_or_col_strobe_out <= next_ale_cas;
      top_addr_or_row_strobe_out <= next_top_ras;
      mem_write_enable_n_out <= next_wr;
      mem_read_enable_n_out <= next_rd;
      sram_ad_rd_out <= next_sram_rd;
      dram_data_rd_out <= next_dram_rd;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // the read path looks three edges back; wait for that much history after reset
  logic [1:0] up_cnt;
  logic [1:0] next_up_cnt;
  always_comb begin
    next_up_cnt = (up_cnt == 2'h3) ? up_cnt : 2'(up_cnt + 2'h1);
  end
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      up_cnt <= 2'h0;
    end else begin
      up_cnt <= next_up_cnt;
    end
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  static_ad_a: assert property (
    mode_out == mem_pin_pkg::PIN_MODE_STATIC |-> shared_line_out == $past(sram_ad_out_in)
      && shared_line_oe_out == {8{$past(sram_ad_oe_in)}})
    else $error("static shared lines do not follow address/data");
  read_path_a: assert property (
    up_cnt == 2'h3 |-> sram_ad_rd_out == $past(shared_line_in, 3))
    else $error("shared line read data not three cycles behind the pins");
  dyn_addr_a: assert property (
    mode_out == mem_pin_pkg::PIN_MODE_DYNAMIC |->
      shared_line_out[7:4] == $past(dram_addr_in[3:0]) && shared_line_oe_out[7:4] == 4'hf)
    else $error("dynamic low address wrong on shared lines 4 to 7");
  dyn_data_a: assert property (
    mode_out == mem_pin_pkg::PIN_MODE_DYNAMIC |->
      shared_line_out[3:0] == $past(dram_data_out_in)
      && shared_line_oe_out[3:0] == {4{$past(dram_data_oe_in)}}
      && dram_data_rd_out == sram_ad_rd_out[3:0])
    else $error("dynamic data lines wrong");
  upper_map_a: assert property (
    upper_addr_pin_out == (mode_out == mem_pin_pkg::PIN_MODE_STATIC ?
      $past(sram_addr_hi_in[12:8]) : mode_out == mem_pin_pkg::PIN_MODE_DYNAMIC ?
      $past(dram_addr_in[8:4]) : 5'h1f))
    else $error("upper address pins wrong for mode");
  ale_cas_a: assert property (
    addr_latch_or_col_strobe_out == (mode_out == mem_pin_pkg::PIN_MODE_STATIC ?
      $past(sram_ale_in) : mode_out == mem_pin_pkg::PIN_MODE_DYNAMIC ?
      $past(dram_cas_n_in) : 1'h1))
    else $error("latch enable or column strobe wrong");
  top_ras_a: assert property (
    top_addr_or_row_strobe_out == (mode_out == mem_pin_pkg::PIN_MODE_STATIC ?
      $past(sram_addr_hi_in[13]) : mode_out == mem_pin_pkg::PIN_MODE_DYNAMIC ?
      $past(dram_ras_n_in) : 1'h1))
    else $error("address 13 or row strobe wrong");
  write_en_a: assert property (
    mode_out != mem_pin_pkg::PIN_MODE_IDLE |-> mem_write_enable_n_out == $past(mem_write_enable_n_in))
    else $error("write enable does not follow in active mode");
  read_en_a: assert property (
    mode_out != mem_pin_pkg::PIN_MODE_IDLE |-> mem_read_enable_n_out == $past(mem_read_enable_n_in))
    else $error("read enable does not follow in active mode");
  idle_safe_a: assert property (
    mode_out == mem_pin_pkg::PIN_MODE_IDLE |-> shared_line_oe_out == 8'hf0
      && shared_line_out[7:4] == 4'hf && mem_write_enable_n_out && mem_read_enable_n_out)
    else $error("unconfigured pins not in safe state");
  // the first edge after reset shows the reset mode, whatever the setting was before
  mode_follow_a: assert property (
    up_cnt != 2'h0 |-> mode_out == (!$past(mode_configured_in) ? mem_pin_pkg::PIN_MODE_IDLE :
      $past(mode_dynamic_in) ? mem_pin_pkg::PIN_MODE_DYNAMIC : mem_pin_pkg::PIN_MODE_STATIC))
    else $error("mode setting not taken");

  static_seen_c: cover property (mode_out == mem_pin_pkg::PIN_MODE_STATIC && sram_ad_oe_in);
  dynamic_seen_c: cover property (mode_out == mem_pin_pkg::PIN_MODE_DYNAMIC && dram_data_oe_in);
  switch_c: cover property (mode_out == mem_pin_pkg::PIN_MODE_STATIC
    ##1 mode_out == mem_pin_pkg::PIN_MODE_DYNAMIC);
endmodule : memory_port_pin_mux

// [dv/mem_chip_model.sv]
// behavioural external memory chip on the shared lines of the memory port
`timescale 1ns/1ns
module mem_chip_model (
  // clock
  input wire logic sys_clk_in,
  // port pins seen by the chip
  input wire logic [7:0] shared_line_out_in,
  input wire logic [7:0] shared_line_oe_in,
  input wire logic mem_read_enable_n_in,
  // resolved pin level
  output logic [7:0] line_level_out
);
  logic [7:0] chip_data = 8'h3c;
  // ----------------------------------------------------------------
  // chip drive
  // ----------------------------------------------------------------
  // the pattern moves every cycle so a released line never looks like a held one
  always @(negedge sys_clk_in) begin
    chip_data <= {chip_data[6:0], ~chip_data[7]};
  end
  // port drive wins where enabled; else the chip drives its pattern, inverted while read enable is high
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (shared_line_oe_in[i]) begin
        line_level_out[i] = shared_line_out_in[i];
      end else begin
        line_level_out[i] = mem_read_enable_n_in ? ~chip_data[i] : chip_data[i];
      end
    end
  end
endmodule : mem_chip_model

// [dv/tb.sv]
// self-checking bench for the memory port pin mux
`timescale 1ns/1ns
module tb;
  logic sys_clk_in = 1'b0;
  logic rst_n_in;
  logic [35:0] stim = '0;
  logic [26:0] exp_pins;
  logic [31:0] rnd = 32'h00011d20;
  logic [7:0] line_level, h0, h1, h2;
  logic [7:0] sram_ad_rd_out, shared_line_out, shared_line_oe_out;
  logic [3:0] dram_data_rd_out;
  logic [4:0] upper_addr_pin_out;
  logic alc_pin, top_pin, we_pin, re_pin;
  mem_pin_pkg::pin_mode_e mode_out;
  int failures = 0;
  int checked = 0;
  always #25 sys_clk_in = ~sys_clk_in;
  memory_port_pin_mux i_memory_port_pin_mux (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .mode_configured_in(stim[0]), .mode_dynamic_in(stim[1]),
    .sram_ad_out_in(stim[9:2]), .sram_ad_oe_in(stim[10]), .sram_addr_hi_in(stim[16:11]),
    .sram_ale_in(stim[17]), .sram_ad_rd_out(sram_ad_rd_out),
    .dram_addr_in(stim[26:18]), .dram_data_out_in(stim[30:27]), .dram_data_oe_in(stim[31]),
    .dram_ras_n_in(stim[32]), .dram_cas_n_in(stim[33]), .dram_data_rd_out(dram_data_rd_out),
    .mem_write_enable_n_in(stim[34]), .mem_read_enable_n_in(stim[35]),
    .shared_line_in(line_level), .shared_line_out(shared_line_out),
    .shared_line_oe_out(shared_line_oe_out), .upper_addr_pin_out(upper_addr_pin_out),
    .addr_latch_or_col_strobe_out(alc_pin), .top_addr_or_row_strobe_out(top_pin),
    .mem_write_enable_n_out(we_pin), .mem_read_enable_n_out(re_pin), .mode_out(mode_out));
  mem_chip_model i_mem_chip_model (
    .sys_clk_in(sys_clk_in), .shared_line_out_in(shared_line_out),
    .shared_line_oe_in(shared_line_oe_out), .mem_read_enable_n_in(re_pin),
    .line_level_out(line_level));
  // ----------------------------------------------------------------
  // expectations
  // ----------------------------------------------------------------
  // read path: two sync stages plus the output register
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      {h0, h1, h2} <= '0;
    end else begin
      {h0, h1, h2} <= {line_level, h0, h1};
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction : xs
  // drive value is masked by enable: an undriven line's value is free
  function automatic logic [26:0] expect_pins(input logic [35:0] s);
    if (!s[0]) return {mem_pin_pkg::PIN_MODE_IDLE, 8'hf0, 8'hf0, 5'h1f, 4'hf};
    if (!s[1]) return {mem_pin_pkg::PIN_MODE_STATIC, s[9:2] & {8{s[10]}}, {8{s[10]}},
                       s[15:11], s[17], s[16], s[34], s[35]};
    return {mem_pin_pkg::PIN_MODE_DYNAMIC, s[21:18], s[30:27] & {4{s[31]}}, 4'hf,
            {4{s[31]}}, s[26:22], s[33], s[32], s[34], s[35]};
  endfunction : expect_pins
  // ----------------------------------------------------------------
  // checking and stepping
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] want, input string what);
    checked++;
    if (got !== want) begin
      failures++;
      $display("[ERR] %0t %s got %h want %h", $time, what, got, want);
    end
  endtask : check
  task automatic cycle(input logic [35:0] s, input logic rst);
    logic [26:0] got;
    @(negedge sys_clk_in);
    got = {mode_out, shared_line_out & shared_line_oe_out, shared_line_oe_out,
           upper_addr_pin_out, alc_pin, top_pin, we_pin, re_pin};
    check(32'(got[26:25]), 32'(exp_pins[26:25]), "mode");
    check(32'(got[24:9]), 32'(exp_pins[24:9]), "shared");
    check(32'(got[8:4]), 32'(exp_pins[8:4]), "upper");
    check(32'(got[3:2]), 32'(exp_pins[3:2]), "strobes");
    check(32'(got[1:0]), 32'(exp_pins[1:0]), "enables");
    check(32'(sram_ad_rd_out), 32'(h2), "static read");
    check(32'(dram_data_rd_out), 32'(h2[3:0]), "dynamic read");
    rst_n_in = rst;
    stim = s;
    exp_pins = rst ? expect_pins(s) : expect_pins('0);
  endtask : cycle
  task automatic conclude();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : conclude
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [35:0] s;
    rst_n_in = 1'b1;
    exp_pins = expect_pins('0);
    #1 rst_n_in = 1'b0;
    repeat (20) cycle('0, 1'b0);
    cycle({9'h0, 9'h1a5, 18'h3}, 1'b1);
    for (int i = 0; i < 600; i++) begin
      rnd = xs(rnd);
      s[31:0] = rnd;
      rnd = xs(rnd);
      s[35:32] = rnd[3:0];
      // first cycles flip static and dynamic back to back, later mostly random
      s[1:0] = (i < 16) ? {i[0], 1'b1} : {s[1], rnd[6:4] != 3'h0};
      cycle(s, !(i inside {300, 301}));
    end
    cycle('0, 1'b1);
    cycle('0, 1'b1);
    conclude();
  end
  initial begin
    #(50 * 2000);
    failures++;
    conclude();
  end
endmodule : tb
